/* File: rtl/doc_pkg.sv */
/*
 * Package for the directional phase overcurrent block: register map,
 * field layouts, reset values, measurement and setting carriers.
 * Assumes measurements arrive as integer magnitudes and whole degrees.
 */
package doc_pkg;

    // Stage and setting-group counts
    localparam int unsigned N_STAGE = 4;
    localparam int unsigned N_GROUP = 4;
    localparam int unsigned N_DEP_STAGES = 2;

    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_EVENT  = 12'h008;
    localparam logic [11:0] ADDR_MASK   = 12'h00C;
    localparam logic [11:0] ADDR_MEMDUR = 12'h010;
    localparam logic [3:0]  SET_PAGE    = 4'h1;
    localparam logic [1:0]  FLD_PICKUP  = 2'h0;
    localparam logic [1:0]  FLD_ANGLE   = 2'h1;
    localparam logic [1:0]  FLD_DELAY   = 2'h2;
    localparam logic [1:0]  FLD_MODE    = 2'h3;

    // Reset values (delays and memory duration in 10 ms ticks)
    localparam logic [15:0] RST_PICKUP  = 16'h0FA0;
    localparam logic [14:0] RST_DELAY   = 15'h000A;
    localparam logic [8:0]  RST_MEMDUR  = 9'h064;

    // Angles in whole degrees
    localparam logic signed [10:0] DEG_90     = 11'sd90;
    localparam logic signed [10:0] DEG_180    = 11'sd180;
    localparam logic signed [10:0] DEG_179    = 11'sd179;
    localparam logic signed [10:0] DEG_360    = 11'sd360;
    localparam logic signed [10:0] SECTOR_DEG = 11'sd88;

    // Currents in mA, voltages in 10 mV units, secondary side
    localparam logic [15:0] I_RATED     = 16'h03E8;
    localparam logic [5:0]  I_SAT_MULT  = 6'h32;
    localparam logic [15:0] V_MIN_POL   = 16'h00C8;
    localparam logic [15:0] V_LL_LOW    = 16'h0064;

    // Timing
    localparam int unsigned CLK_HZ      = 125_000_000;
    localparam int unsigned TICK_MS     = 10;
    localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned MEM_DEPTH   = 8;

    typedef enum logic [1:0] {
        MODE_DIR    = 2'b00,
        MODE_NONDIR = 2'b01,
        MODE_BACKUP = 2'b10
    } doc_mode_t;

    typedef struct packed {
        logic [15:0]       ia;
        logic [15:0]       ib;
        logic [15:0]       ic;
        logic signed [8:0] i1_ang;
        logic signed [8:0] u1_ang;
        logic [15:0]       u1_mag;
        logic              gnd;
        logic signed [8:0] fi_ang;
        logic signed [8:0] ll_ang;
        logic [15:0]       ll_mag;
        logic [15:0]       ll_max;
        logic signed [8:0] pg_ang;
    } doc_meas_t;

    typedef struct packed {
        logic [15:0]       pickup;
        logic signed [8:0] angle;
        logic [14:0]       delay;
        doc_mode_t         mode;
        logic              dep;
    } doc_set_t;

endpackage : doc_pkg

/* File: rtl/doc_stage.sv */
/*
 * Four-stage directional phase overcurrent block with APB registers,
 * setting groups, angle memory and start/trip event interrupt.
 * Assumes measurement inputs are synchronous to clk and already filtered
 * to fundamental phasors by the front end.
 */
`timescale 1ns/1ps

// Notes on behaviour
// [R1] Non-ground faults use positive-sequence polarization, ground faults cross-polarization.
// [R2] Overcurrent when largest phase current magnitude exceeds start setting.
// [R3] Start while current and direction both hold; trip after delay elapses.
// [R4] Non-ground reference is positive-sequence voltage plus base angle, sector 88 degrees.
// [R5] Positive-sequence current magnitude affects neither decision.
// [R6] Ground reference is inverted healthy line voltage rotated base plus 90.
// [R7] Directional, non-directional and backup modes; non-directional ignores direction.
// [R8] Backup mode goes non-directional once angle memory expires on collapsed voltage.
// [R9] Four stages; first two choose definite or dependent delay.
// [R10] Third and fourth stages have definite delay only.
// [R11] Measured current saturates at fifty times rated, bounding dependent timing.
// [R12] Four setting groups per stage; active group supplies its settings.
// [R13] No direction resolved below 2 V polarizing voltage.
// [R14] Cyclic angle buffer gives reference when all line voltages drop below 1%.
// [R15] Block input forces start and trip inactive.
// [R16] Start and trip transitions record events only when enabled.
module doc_stage
    import doc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata_q,
    output logic                      pready_q,
    output logic                      pslverr_q,
    // Measurements and stage control
    input  wire doc_meas_t            meas,
    input  wire logic [N_STAGE-1:0]   block,
    // Stage outputs
    output logic      [N_STAGE-1:0]   start_q,
    output logic      [N_STAGE-1:0]   trip_q,
    output logic                      irq_q
);

    function automatic logic signed [10:0] wrap(logic signed [10:0] a);
        logic signed [10:0] r;
        r = a;
        if (r > DEG_179) r = r - DEG_360;
        if (r > DEG_179) r = r - DEG_360;
        if (r < -DEG_180) r = r + DEG_360;
        if (r < -DEG_180) r = r + DEG_360;
        return r;
    endfunction : wrap

    function automatic logic in_sector(logic signed [10:0] cur,
                                       logic signed [10:0] ref_ang);
        logic signed [10:0] d;
        d = wrap(cur - ref_ang);
        return (d <= SECTOR_DEG) && (d >= -SECTOR_DEG);
    endfunction : in_sector

    // Register state
    logic [2*N_STAGE-1:0]   grp_q;
    logic [N_STAGE-1:0]     evt_en_q;
    logic [2*N_STAGE-1:0]   evt_q;
    logic [2*N_STAGE-1:0]   mask_q;
    logic [8:0]             memdur_q;
    doc_set_t               set_q [N_STAGE*N_GROUP];

    // Bus decode
    logic        acc;
    logic        wr_en;
    logic        rd_done;
    logic        is_set;
    logic [3:0]  set_idx;
    logic        mapped;
    assign acc     = psel & penable & pready_q;
    assign wr_en   = ce & acc & pwrite;
    assign rd_done = ce & acc & ~pwrite;
    assign is_set  = paddr[11:8] == SET_PAGE;
    assign set_idx = paddr[7:4];
    assign mapped  = is_set || paddr == ADDR_CTRL || paddr == ADDR_STATUS
                     || paddr == ADDR_EVENT || paddr == ADDR_MASK
                     || paddr == ADDR_MEMDUR;

    // Time base: one pulse every 10 ms
    logic [31:0] tick_cnt_q;
    logic        tick;
    assign tick = tick_cnt_q == TICK_CYCLES - 1;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 32'h0;
        end else if (ce) begin
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
        end
    end

    // Control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grp_q    <= '0;
            evt_en_q <= '0;
            mask_q   <= '0;
            memdur_q <= RST_MEMDUR;
        end else if (wr_en) begin
            if (paddr == ADDR_CTRL) begin
                grp_q    <= pwdata[2*N_STAGE-1:0];
                evt_en_q <= pwdata[3*N_STAGE-1:2*N_STAGE];
            end
            if (paddr == ADDR_MASK) mask_q <= pwdata[2*N_STAGE-1:0];
            if (paddr == ADDR_MEMDUR) memdur_q <= pwdata[8:0];
        end
    end

    // Setting banks: one per stage and group
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N_STAGE * N_GROUP; i++) begin
                set_q[i] <= '{RST_PICKUP, 9'sh000, RST_DELAY,
                              MODE_DIR, 1'b0};
            end
        end else if (wr_en && is_set) begin
            case (paddr[3:2])
                FLD_PICKUP: set_q[set_idx].pickup <= pwdata[15:0];
                FLD_ANGLE:  set_q[set_idx].angle  <= pwdata[8:0];
                FLD_DELAY:  set_q[set_idx].delay  <= pwdata[14:0];
                FLD_MODE: begin
                    set_q[set_idx].mode <= doc_mode_t'(pwdata[1:0]);
                    // Only the first two stages offer dependent delay
                    set_q[set_idx].dep  <= pwdata[2] &&
                        (set_idx[3:2] < 2'(N_DEP_STAGES)); // [R9] [R10]
                end
                default: ;
            endcase
        end
    end

    // Largest phase current, saturated at 50 x rated
    logic [21:0] i_sat;
    logic [15:0] i_max;
    logic [15:0] i_lim;
    assign i_sat = I_RATED * I_SAT_MULT;
    always_comb begin
        i_max = meas.ia;
        if (meas.ib > i_max) i_max = meas.ib;
        if (meas.ic > i_max) i_max = meas.ic;
        i_lim = (22'(i_max) > i_sat) ? i_sat[15:0] : i_max; // [R11]
    end

    // Angle memory: cyclic buffer of phase-to-ground angles
    logic signed [8:0] mem_q [MEM_DEPTH];
    logic [2:0]        mem_wr_q;
    logic [8:0]        mem_age_q;
    logic              ll_low;
    logic              mem_live;
    assign ll_low   = meas.ll_max < V_LL_LOW; // [R14]
    assign mem_live = ll_low && (mem_age_q < memdur_q);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < MEM_DEPTH; i++) mem_q[i] <= 9'sh000;
            mem_wr_q  <= 3'h0;
            mem_age_q <= 9'h000;
        end else if (ce && tick) begin
            if (!ll_low) begin
                mem_q[mem_wr_q] <= meas.pg_ang; // [R14]
                mem_wr_q        <= mem_wr_q + 3'h1;
                mem_age_q       <= 9'h000;
            end else if (mem_age_q != 9'h1FF) begin
                mem_age_q <= mem_age_q + 9'h001;
            end
        end
    end

    // Per-stage decisions
    doc_set_t               act [N_STAGE];
    logic [N_STAGE-1:0]     oc;
    logic [N_STAGE-1:0]     dir;
    logic [N_STAGE-1:0]     start_d;
    always_comb begin
        logic signed [10:0] base;
        logic signed [10:0] cur;
        logic signed [10:0] ref_ang;
        logic [15:0]        pol;
        base = '0;
        cur = '0;
        ref_ang = '0;
        pol = '0;
        for (int s = 0; s < N_STAGE; s++) begin
            act[s] = set_q[s*N_GROUP + int'(grp_q[2*s +: 2])]; // [R12]
            base   = 11'(act[s].angle);
            // Only magnitudes of phase currents enter the threshold
            oc[s]  = i_lim > act[s].pickup; // [R2] [R5]
            if (meas.gnd) begin
                cur     = 11'(meas.fi_ang); // [R1]
                ref_ang = wrap(11'(meas.ll_ang) + DEG_180
                               + base + DEG_90); // [R6]
                pol     = meas.ll_mag;
            end else begin
                cur     = 11'(meas.i1_ang); // [R1]
                ref_ang = wrap(11'(meas.u1_ang) + base); // [R4]
                pol     = meas.u1_mag;
            end
            if (ll_low) begin
                // Voltage collapsed: stored angle or backup decides
                if (mem_live)
                    dir[s] = in_sector(cur, wrap(11'(mem_q[mem_wr_q])
                                                 + base)); // [R14]
                else
                    dir[s] = act[s].mode == MODE_BACKUP; // [R8]
            end else begin
                dir[s] = (pol >= V_MIN_POL) && in_sector(cur, ref_ang); // [R13]
            end
            if (act[s].mode == MODE_NONDIR) dir[s] = 1'b1; // [R7]
            start_d[s] = oc[s] && dir[s] && !block[s]; // [R3] [R15]
        end
    end

    // Operate delay: definite counts ticks, dependent integrates current
    logic [31:0]        acc_q [N_STAGE];
    logic [N_STAGE-1:0] trip_d;
    always_comb begin
        for (int s = 0; s < N_STAGE; s++) begin
            if (act[s].dep)
                trip_d[s] = start_d[s] && acc_q[s]
                            >= 32'(act[s].delay) * 32'(act[s].pickup);
            else
                trip_d[s] = start_d[s] && acc_q[s] >= 32'(act[s].delay); // [R3]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < N_STAGE; s++) acc_q[s] <= 32'h0;
        end else if (ce) begin
            for (int s = 0; s < N_STAGE; s++) begin
                if (!start_d[s])
                    acc_q[s] <= 32'h0;
                else if (tick && acc_q[s] < 32'h8000_0000)
                    acc_q[s] <= acc_q[s] + (act[s].dep ? 32'(i_lim)
                                                       : 32'h1); // [R9] [R11]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= '0;
            trip_q  <= '0;
        end else if (ce) begin
            start_q <= start_d; // [R3]
            trip_q  <= trip_d;  // [R3] [R15]
        end
    end

    // Sticky events; a new event outranks the read that clears
    logic [2*N_STAGE-1:0] evt_set;
    assign evt_set = {(trip_d ^ trip_q) & evt_en_q,
                      (start_d ^ start_q) & evt_en_q}; // [R16]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_q <= '0;
        end else if (ce) begin
            // Clear only what the read reported; later bits survive
            if (rd_done && paddr == ADDR_EVENT)
                evt_q <= (evt_q & ~prdata_q[2*N_STAGE-1:0]) | evt_set;
            else
                evt_q <= evt_q | evt_set;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(evt_q & mask_q);
        end
    end

    // APB answer: one wait-free access cycle after setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else if (ce) begin
            pready_q  <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~mapped;
            prdata_q  <= 32'h0;
            if (psel && !penable && !pwrite) begin
                if (is_set) begin
                    case (paddr[3:2])
                        FLD_PICKUP: prdata_q <= 32'(set_q[set_idx].pickup);
                        FLD_ANGLE:  prdata_q <= 32'(set_q[set_idx].angle);
                        FLD_DELAY:  prdata_q <= 32'(set_q[set_idx].delay);
                        default:    prdata_q <= 32'({set_q[set_idx].dep,
                                                     set_q[set_idx].mode});
                    endcase
                end else begin
                    case (paddr)
                        ADDR_CTRL:   prdata_q <= 32'({evt_en_q, grp_q});
                        ADDR_STATUS: prdata_q <= 32'({ll_low & ~mem_live,
                                                      mem_live, trip_q,
                                                      start_q});
                        ADDR_EVENT:  prdata_q <= 32'(evt_q);
                        ADDR_MASK:   prdata_q <= 32'(mask_q);
                        ADDR_MEMDUR: prdata_q <= 32'(memdur_q);
                        default:     prdata_q <= 32'h0;
                    endcase
                end
            end
        end
    end

endmodule : doc_stage

/* File: tb/doc_stage_chk.sv */
/*
 * Port checker for doc_stage: APB handshake, blocking, trip order.
 * Assumes it is bound to doc_stage and sees only its ports.
 */
`timescale 1ns/1ps
module doc_stage_chk
    import doc_pkg::*;
(
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    // Enable and APB
    input wire logic               ce,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic [31:0]        prdata_q,
    input wire logic               pready_q,
    input wire logic               pslverr_q,
    // Stage side
    input wire logic [N_STAGE-1:0] block,
    input wire logic [N_STAGE-1:0] start_q,
    input wire logic [N_STAGE-1:0] trip_q,
    input wire logic               irq_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    block_forces_a: assert property (
        ce && |block |=> ((start_q | trip_q) & $past(block)) == '0)
        else $error("blocked stage still active");
    start_unblocked_a: assert property (
        (start_q & ~$past(start_q) & $past(block)) == '0)
        else $error("start rose while blocked");
    trip_needs_start_a: assert property (
        (trip_q & ~start_q) == '0)
        else $error("trip without start");
    trip_after_start_a: assert property (
        (trip_q & ~$past(trip_q) & ~$past(start_q)) == '0)
        else $error("trip rose before start");
    ready_pulse_a: assert property (pready_q |=> !pready_q)
        else $error("ready held over two cycles");
    ready_setup_a: assert property (
        ce && psel && !penable |=> pready_q)
        else $error("no ready after setup");
    ready_cause_a: assert property (
        pready_q |-> psel && penable && $past(psel && !penable))
        else $error("ready outside first access cycle");
    error_data_a: assert property (
        pslverr_q |-> pready_q && prdata_q == 32'h0)
        else $error("error response malformed");

    cover property ($rose(start_q[0]));
    cover property ($rose(trip_q[0]));
    cover property (pslverr_q);
    cover property ($rose(irq_q));
endmodule : doc_stage_chk

/* File: tb/doc_fe_model.sv */
/*
 * Front-end model: turns a fault scene into measurement phasors.
 * Assumes the bench sets the scene by non-blocking assignment at clk.
 */
`timescale 1ns/1ps
module doc_fe_model
    import doc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Fault scene
    input  wire logic [15:0]       cur,
    input  wire logic signed [8:0] i_ang,
    input  wire logic signed [8:0] v_ang,
    input  wire logic [15:0]       v_mag,
    input  wire logic              gnd,
    // Phasors to the stage
    output doc_meas_t              meas
);
    // Fault current on phase C, so the largest phase is not phase A when cur exceeds 100 mA
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meas <= '0;
        end else begin
            meas.ia     <= 16'h0064;
            meas.ib     <= 16'h0032;
            meas.ic     <= cur;
            meas.i1_ang <= i_ang;
            meas.fi_ang <= i_ang;
            meas.u1_ang <= v_ang;
            meas.ll_ang <= v_ang;
            meas.pg_ang <= v_ang;
            meas.u1_mag <= v_mag;
            meas.ll_mag <= v_mag;
            meas.ll_max <= v_mag;
            meas.gnd    <= gnd;
        end
    end
endmodule : doc_fe_model

/* File: tb/testbench.sv */
/*
 * Bench for doc_stage: APB master, fault scenes, stage timing, events.
 * Assumes doc_pkg, doc_stage, doc_fe_model and doc_stage_chk.
 */
`timescale 1ns/1ps
module testbench
    import doc_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              ce = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0;
    logic [3:0]        block = 4'h0;
    logic [15:0]       cur = 16'h0;
    logic [15:0]       vm = 16'h0;
    logic signed [8:0] ia = 9'h0;
    logic signed [8:0] va = 9'h0;
    logic              gnd = 1'b0;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [3:0]        start_q;
    logic [3:0]        trip_q;
    logic              irq_q;
    doc_meas_t         meas;
    logic [31:0]       r;
    logic              e;
    int                mismatches = 0;
    int                checked = 0;
    int                cyc = 0;

    always #4 clk = ~clk;

    doc_stage #(.TICK_CYCLES(10)) u_doc_stage (
        .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
        .pslverr_q(pslverr_q), .meas(meas), .block(block),
        .start_q(start_q), .trip_q(trip_q), .irq_q(irq_q));
    doc_fe_model u_doc_fe_model (
        .clk(clk), .rst_n(rst_n), .cur(cur), .i_ang(ia), .v_ang(va),
        .v_mag(vm), .gnd(gnd), .meas(meas));

    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] x);
        checked++;
        if (seen !== x) begin
            mismatches++;
            $display("unexpected at %0t: %h vs %h", $time, seen, x);
        end
    endtask : chk

    // Waits on ready without a local limit; the cycle ceiling ends a hang
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready_q !== 1'b1);
        r = prdata_q;
        e = pslverr_q;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask : rd

    function automatic logic [11:0] adr(input logic [1:0] s, g, f);
        return {SET_PAGE, s, g, f, 2'b00};
    endfunction : adr

    task automatic sc(input logic [15:0] c, input logic signed [8:0] i,
                      input logic signed [8:0] v, input logic [15:0] m,
                      input logic g, input logic [3:0] x);
        @(posedge clk);
        cur <= c;
        ia  <= i;
        va  <= v;
        vm  <= m;
        gnd <= g;
        repeat (3) @(posedge clk);
        chk(32'(start_q), 32'(x));
    endtask : sc

    task automatic t_regs;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_MASK, 32'h0);
        rd(ADDR_MEMDUR, 32'h0000_0064);
        rd(adr(2'h3, 2'h3, FLD_PICKUP), 32'h0000_0FA0);
        rd(adr(2'h0, 2'h0, FLD_DELAY), 32'h0000_000A);
        rd(adr(2'h2, 2'h1, FLD_MODE), 32'h0);
        rd(12'hFFC, 32'h0);
        chk(32'(e), 32'h1);
    endtask : t_regs

    task automatic t_sector;
        sc(16'h0FA0, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'h0);
        sc(16'h0FA1, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'hF);
        sc(16'h1388, 9'sh50, 9'sh0, 16'h03E8, 1'b0, 4'hF);
        sc(16'h1388, -9'sh50, 9'sh0, 16'h03E8, 1'b0, 4'hF);
        sc(16'h1388, 9'sh64, 9'sh0, 16'h03E8, 1'b0, 4'h0);
        sc(16'h1388, -9'sh64, 9'sh0, 16'h03E8, 1'b0, 4'h0);
        sc(16'h1388, 9'sh0, 9'sh5A, 16'h03E8, 1'b0, 4'h0);
        sc(16'h1388, 9'sh0, 9'sh0, 16'h00C7, 1'b0, 4'h0);
        sc(16'h1388, 9'sh0, 9'sh0, 16'h00C8, 1'b0, 4'hF);
    endtask : t_sector

    task automatic t_base;
        apb(1'b1, adr(2'h1, 2'h0, FLD_ANGLE), 32'h0000_01E2);
        sc(16'h1388, -9'sh64, 9'sh0, 16'h03E8, 1'b0, 4'h2);
        sc(16'h1388, 9'sh3C, 9'sh0, 16'h03E8, 1'b0, 4'hD);
        apb(1'b1, adr(2'h1, 2'h0, FLD_ANGLE), 32'h0);
    endtask : t_base

    task automatic t_ground;
        sc(16'h1388, -9'sh6E, 9'sh0, 16'h03E8, 1'b1, 4'hF);
        sc(16'h1388, 9'sh0, 9'sh0, 16'h03E8, 1'b1, 4'h0);
    endtask : t_ground

    task automatic t_mode;
        apb(1'b1, adr(2'h0, 2'h0, FLD_MODE), 32'h1);
        sc(16'h1388, -9'shB4, 9'sh0, 16'h03E8, 1'b0, 4'h1);
        apb(1'b1, adr(2'h0, 2'h0, FLD_MODE), 32'h4);
        rd(adr(2'h0, 2'h0, FLD_MODE), 32'h4);
        apb(1'b1, adr(2'h2, 2'h0, FLD_MODE), 32'h4);
        rd(adr(2'h2, 2'h0, FLD_MODE), 32'h0);
        apb(1'b1, adr(2'h0, 2'h0, FLD_MODE), 32'h0);
        sc(16'h0, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'h0);
    endtask : t_mode

    task automatic t_group;
        apb(1'b1, adr(2'h0, 2'h1, FLD_PICKUP), 32'h0000_03E8);
        apb(1'b1, ADDR_CTRL, 32'h1);
        sc(16'h07D0, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'h1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        sc(16'h07D0, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'h0);
    endtask : t_group

    task automatic t_trip;
        int n;
        n = 0;
        sc(16'h1388, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'hF);
        while (trip_q !== 4'hF) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n > 80 && n < 115), 32'h1);
        rd(ADDR_STATUS, 32'h0000_00FF);
        // Enable low freezes outputs even against a block
        ce    <= 1'b0;
        block <= 4'hF;
        repeat (3) @(posedge clk);
        chk(32'(start_q), 32'hF);
        ce    <= 1'b1;
        block <= 4'h1;
        repeat (2) @(posedge clk);
        chk({24'h0, start_q, trip_q}, 32'h0000_00EE);
        block <= 4'h0;
        sc(16'h0, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'h0);
        chk(32'(trip_q), 32'h0);
    endtask : t_trip

    task automatic t_events;
        apb(1'b1, ADDR_CTRL, 32'h0000_0100);
        apb(1'b1, ADDR_MASK, 32'h0000_0011);
        rd(ADDR_EVENT, 32'h0);
        sc(16'h1388, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'hF);
        repeat (3) @(posedge clk);
        chk(32'(irq_q), 32'h1);
        rd(ADDR_EVENT, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(32'(irq_q), 32'h0);
        apb(1'b1, ADDR_MASK, 32'h0);
        sc(16'h0, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'h0);
        repeat (3) @(posedge clk);
        chk(32'(irq_q), 32'h0);
        rd(ADDR_EVENT, 32'h0000_0001);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h0000_0011);
        sc(16'h1388, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'hF);
        rd(ADDR_EVENT, 32'h0);
        chk(32'(irq_q), 32'h0);
    endtask : t_events

    // 65535 mA saturates to 50000: ten ticks reach 500000, eight if not
    task automatic t_dep;
        int n;
        n = 0;
        sc(16'h0, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'h0);
        apb(1'b1, adr(2'h0, 2'h0, FLD_PICKUP), 32'h0000_03E8);
        apb(1'b1, adr(2'h0, 2'h0, FLD_DELAY), 32'h0000_01F4);
        apb(1'b1, adr(2'h0, 2'h0, FLD_MODE), 32'h4);
        sc(16'hFFFF, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'hF);
        while (trip_q[0] !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n > 85 && n < 110), 32'h1);
        sc(16'h0, 9'sh0, 9'sh0, 16'h03E8, 1'b0, 4'h0);
    endtask : t_dep

    // Stored angles are 0 from the healthy scenes that came before
    task automatic t_memory;
        apb(1'b1, ADDR_MEMDUR, 32'h4);
        apb(1'b1, adr(2'h0, 2'h0, FLD_MODE), 32'h2);
        sc(16'h1388, 9'sh0, 9'sh0, 16'h0032, 1'b0, 4'hF);
        sc(16'h1388, 9'sh64, 9'sh0, 16'h0032, 1'b0, 4'h0);
        repeat (60) @(posedge clk);
        chk(32'(start_q), 32'h1);
        rd(ADDR_STATUS, 32'h0000_0201);
    endtask : t_memory

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_sector();
        t_base();
        t_ground();
        t_mode();
        t_group();
        t_trip();
        t_events();
        t_dep();
        t_memory();
        complete_run();
    end
endmodule : testbench

bind doc_stage doc_stage_chk u_doc_stage_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .block(block), .start_q(start_q), .trip_q(trip_q), .irq_q(irq_q));
